// ### rtc_regs.v
// rtc register access: two-wire slave, bcd counters, read latch and scratch bytes
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.vh"
module rtc_regs #(
  parameter [6:0] SLAVE_ID   = 7'h50, // arbitrary value
  parameter       SEC_CYCLES = `RTC_CLK_HZ * `RTC_SECOND_S
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire scl_i,
  input  wire sda_i,
  output wire sda_o,
  output wire sda_oe_n_o
);
  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_AACK = 9'h004;
  localparam [8:0] ST_CMD  = 9'h008;
  localparam [8:0] ST_CACK = 9'h010;
  localparam [8:0] ST_WR   = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RD   = 9'h080;
  localparam [8:0] ST_MACK = 9'h100;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  function [7:0] last_date;
    input [7:0] mon;
    input [7:0] yr;
    reg         leap;
    begin
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
        8'h02: begin
          last_date = leap ? 8'h29 : 8'h28;
        end
        8'h04, 8'h06, 8'h09, 8'h11: begin
          last_date = 8'h30;
        end
        default: begin
          last_date = 8'h31;
        end
      endcase
    end
  endfunction

  // timekeeping target of a read: capture only for these
  function is_time_read;
    input [7:0] c;
    reg   [4:0] i;
    begin
      i = c[`RTC_CMD_IDX_HI:`RTC_CMD_IDX_LO];
      is_time_read = ~c[`RTC_CMD_RAM_BIT] & c[`RTC_CMD_READ_BIT] &
                     (i <= `RTC_IDX_YEAR || i == `RTC_IDX_CENT || i == `RTC_IDX_BURST);
    end
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers and bus events
  // --------------------------------------------------------------------------
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // --------------------------------------------------------------------------
  // one-second enable
  // --------------------------------------------------------------------------
  reg [31:0] div_q;
  wire       sec_tick = (div_q == SEC_CYCLES - 1);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 32'h0000_0000;
    end else if (sec_tick) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // serial slave
  // --------------------------------------------------------------------------
  reg  [8:0] st_q;
  reg  [3:0] cnt_q;
  reg  [7:0] sh_q;
  reg  [7:0] tx_q;
  reg  [7:0] cmd_q;
  reg  [4:0] ptr_q;
  reg        burst_q;
  reg        mack_q;
  reg  [1:0] ld_q;
  reg        wr_p_q;
  reg        cap_p_q;
  reg        oe_n_q;
  wire [7:0] rd_byte;
  wire [4:0] cmd_idx = sh_q[`RTC_CMD_IDX_HI:`RTC_CMD_IDX_LO];
  wire       ram_sel = cmd_q[`RTC_CMD_RAM_BIT];
  wire [4:0] ptr_wrap = ram_sel ? `RTC_RAM_LAST : `RTC_IDX_CTL;
  wire [4:0] ptr_next = (burst_q && ptr_q != ptr_wrap) ? ptr_q + 5'h01 :
                        (burst_q ? 5'h00 : ptr_q);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'hff;
      cmd_q   <= 8'h00;
      ptr_q   <= 5'h00;
      burst_q <= 1'b0;
      mack_q  <= 1'b0;
      ld_q    <= 2'b00;
      wr_p_q  <= 1'b0;
      cap_p_q <= 1'b0;
    end else begin
      wr_p_q  <= 1'b0;
      cap_p_q <= 1'b0;
      ld_q    <= {ld_q[0], 1'b0};
      if (ld_q[1]) begin
        tx_q <= rd_byte;
      end
      if (bus_start) begin
        st_q  <= ST_ADDR;
        cnt_q <= 4'h0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_ADDR, ST_CMD, ST_WR: begin
            if (scl_rise && cnt_q != 4'h8) begin
              sh_q  <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                st_q <= (sh_q[7:1] == SLAVE_ID) ? ST_AACK : ST_IDLE;
              end else if (st_q == ST_CMD) begin
                st_q    <= ST_CACK;
                cmd_q   <= sh_q;
                burst_q <= (cmd_idx == `RTC_IDX_BURST);
                ptr_q   <= (cmd_idx == `RTC_IDX_BURST) ? 5'h00 : cmd_idx;
                cap_p_q <= is_time_read(sh_q);
              end else begin
                st_q   <= ST_WACK;
                wr_p_q <= 1'b1;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (sh_q[0]) begin
                st_q <= ST_RD;
                ld_q <= 2'b01;
              end else begin
                st_q <= ST_CMD;
              end
            end
          end
          ST_CACK: begin
            if (scl_fall) begin
              st_q <= ST_WR;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              st_q  <= ST_WR;
              ptr_q <= ptr_next;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_q == 4'h7) begin
                st_q  <= ST_MACK;
                cnt_q <= 4'h0;
              end else begin
                tx_q  <= {tx_q[6:0], 1'b1};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s_q;
            end else if (scl_fall) begin
              if (mack_q) begin
                st_q  <= ST_RD;
                ld_q  <= 2'b01;
                ptr_q <= ptr_next;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end
    end
  end

  // sda is open drain: only ever pulled low
  wire drive_low = (st_q == ST_AACK) || (st_q == ST_CACK) || (st_q == ST_WACK) ||
                   (st_q == ST_RD && ld_q == 2'b00 && !tx_q[7]);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~drive_low;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = oe_n_q;

  // --------------------------------------------------------------------------
  // timekeeping counters and read latch
  // --------------------------------------------------------------------------
  reg  [7:0]  sec_q, min_q, hr_q, date_q, mon_q, wday_q, year_q, ctl_q, cent_q, rsv_q;
  reg  [63:0] lat_q;
  reg         tick_pend_q;
  reg  [7:0]  n_sec, n_min, n_hr, n_date, n_mon, n_wday, n_year, n_cent, t_hr;
  wire        wp = ctl_q[`RTC_CTL_WP_BIT];
  wire        wr_ok = cmd_q[`RTC_CMD_ENABLE_BIT] & ~cmd_q[`RTC_CMD_READ_BIT] &
                      (~wp | (~ram_sel & ptr_q == `RTC_IDX_CTL));
  wire        clk_wr = wr_p_q & wr_ok & ~ram_sel;
  wire        ram_wr = wr_p_q & wr_ok & ram_sel & (ptr_q != `RTC_IDX_BURST);
  // a capture defers the pending second by one cycle
  wire        do_inc = tick_pend_q & ~cap_p_q & ~clk_wr;

  always @* begin
    n_sec  = sec_q;
    n_min  = min_q;
    n_hr   = hr_q;
    n_date = date_q;
    n_mon  = mon_q;
    n_wday = wday_q;
    n_year = year_q;
    n_cent = cent_q;
    t_hr   = bcd_inc({3'b000, hr_q[4:0]});
    if (sec_q != 8'h59) begin
      n_sec = bcd_inc(sec_q);
    end else begin
      n_sec = 8'h00;
      if (min_q != 8'h59) begin
        n_min = bcd_inc(min_q);
      end else begin
        n_min = 8'h00;
        if (hr_q[`RTC_HR_12H_BIT]) begin
          if (hr_q[4:0] == 5'h11) begin
            n_hr = {hr_q[7:6], ~hr_q[5], 5'h12};
          end else if (hr_q[4:0] == 5'h12) begin
            n_hr = {hr_q[7:5], 5'h01};
          end else begin
            n_hr = {hr_q[7:5], t_hr[4:0]};
          end
        end else if (hr_q[5:0] == 6'h23) begin
          n_hr = {hr_q[7:6], 6'h00};
        end else begin
          n_hr = bcd_inc(hr_q);
        end
        if (hr_q[`RTC_HR_12H_BIT] ? (hr_q[5] && hr_q[4:0] == 5'h11) : (hr_q[5:0] == 6'h23)) begin
          n_wday = (wday_q == 8'h07) ? 8'h01 : wday_q + 8'h01;
          if (date_q != last_date(mon_q, year_q)) begin
            n_date = bcd_inc(date_q);
          end else begin
            n_date = 8'h01;
            if (mon_q != 8'h12) begin
              n_mon = bcd_inc(mon_q);
            end else begin
              n_mon = 8'h01;
              n_year = (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
              if (year_q == 8'h99) begin
                n_cent = (cent_q == 8'h99) ? 8'h00 : bcd_inc(cent_q);
              end
            end
          end
        end
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sec_q       <= `RTC_RST_SEC;
      min_q       <= `RTC_RST_MIN;
      hr_q        <= `RTC_RST_HR;
      date_q      <= `RTC_RST_DATE;
      mon_q       <= `RTC_RST_MON;
      wday_q      <= `RTC_RST_WDAY;
      year_q      <= `RTC_RST_YEAR;
      ctl_q       <= `RTC_RST_CTL;
      cent_q      <= `RTC_RST_CENT;
      rsv_q       <= `RTC_RST_RSV;
      lat_q       <= 64'h0000_0000_0000_0000;
      tick_pend_q <= 1'b0;
    end else begin
      if (sec_tick) begin
        tick_pend_q <= 1'b1;
      end else if (do_inc) begin
        tick_pend_q <= 1'b0;
      end
      if (cap_p_q) begin
        lat_q <= {cent_q, year_q, wday_q, mon_q, date_q, hr_q, min_q, sec_q};
      end
      if (do_inc) begin
        sec_q  <= n_sec;
        min_q  <= n_min;
        hr_q   <= n_hr;
        date_q <= n_date;
        mon_q  <= n_mon;
        wday_q <= n_wday;
        year_q <= n_year;
        cent_q <= n_cent;
      end
      if (clk_wr) begin
        case (ptr_q)
          `RTC_IDX_SEC:  sec_q  <= sh_q & `RTC_MASK_SEC;
          `RTC_IDX_MIN:  min_q  <= sh_q & `RTC_MASK_MIN;
          `RTC_IDX_HR:   hr_q   <= sh_q & `RTC_MASK_HR;
          `RTC_IDX_DATE: date_q <= sh_q & `RTC_MASK_DATE;
          `RTC_IDX_MON:  mon_q  <= sh_q & `RTC_MASK_MON;
          `RTC_IDX_WDAY: wday_q <= sh_q & `RTC_MASK_WDAY;
          `RTC_IDX_YEAR: year_q <= sh_q;
          `RTC_IDX_CTL:  ctl_q  <= sh_q & `RTC_MASK_CTL;
          `RTC_IDX_CENT: cent_q <= sh_q;
          default: begin
            rsv_q <= rsv_q;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  wire [7:0] ram_rdata;
  reg  [7:0] clk_byte;

  always @* begin
    case (ptr_q)
      `RTC_IDX_SEC:  clk_byte = lat_q[7:0];
      `RTC_IDX_MIN:  clk_byte = lat_q[15:8];
      `RTC_IDX_HR:   clk_byte = lat_q[23:16];
      `RTC_IDX_DATE: clk_byte = lat_q[31:24];
      `RTC_IDX_MON:  clk_byte = lat_q[39:32];
      `RTC_IDX_WDAY: clk_byte = lat_q[47:40];
      `RTC_IDX_YEAR: clk_byte = lat_q[55:48];
      `RTC_IDX_CTL:  clk_byte = ctl_q;
      `RTC_IDX_CENT: clk_byte = lat_q[63:56];
      `RTC_IDX_RSV:  clk_byte = rsv_q;
      default:       clk_byte = 8'h00;
    endcase
  end

  assign rd_byte = ram_sel ? ((ptr_q == `RTC_IDX_BURST) ? 8'h00 : ram_rdata) : clk_byte;

  rtc_scratch_ram #(
    .DEPTH (31),
    .AW    (5)
  ) u_ram (
    .clk_i   (clk_i),
    .we_i    (ram_wr),
    .waddr_i (ptr_q),
    .wdata_i (sh_q),
    .raddr_i (ptr_q),
    .rdata_o (ram_rdata)
  );
endmodule
`default_nettype wire

// ### rtc_map.vh
// register map, command fields, reset values and timing counts of the rtc register block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH

// ----------------------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------------------
`define RTC_CMD_ENABLE_BIT  7
`define RTC_CMD_RAM_BIT     6
`define RTC_CMD_IDX_HI      5
`define RTC_CMD_IDX_LO      1
`define RTC_CMD_READ_BIT    0

// ----------------------------------------------------------------------------
// register indexes (command bits 5..1)
// ----------------------------------------------------------------------------
`define RTC_IDX_SEC         5'h00
`define RTC_IDX_MIN         5'h01
`define RTC_IDX_HR          5'h02
`define RTC_IDX_DATE        5'h03
`define RTC_IDX_MON         5'h04
`define RTC_IDX_WDAY        5'h05
`define RTC_IDX_YEAR        5'h06
`define RTC_IDX_CTL         5'h07
`define RTC_IDX_CENT        5'h09
`define RTC_IDX_RSV         5'h0b
`define RTC_IDX_BURST       5'h1f
`define RTC_RAM_LAST        5'h1e

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RTC_RST_SEC         8'h00
`define RTC_RST_MIN         8'h00
`define RTC_RST_HR          8'h00
`define RTC_RST_DATE        8'h01
`define RTC_RST_MON         8'h01
`define RTC_RST_WDAY        8'h01
`define RTC_RST_YEAR        8'h70
`define RTC_RST_CTL         8'h00
`define RTC_RST_CENT        8'h19
`define RTC_RST_RSV         8'h07

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define RTC_HR_12H_BIT      7
`define RTC_HR_PM_BIT       5
`define RTC_CTL_WP_BIT      7
`define RTC_MASK_SEC        8'h7f
`define RTC_MASK_MIN        8'h7f
`define RTC_MASK_HR         8'hbf
`define RTC_MASK_DATE       8'h3f
`define RTC_MASK_MON        8'h1f
`define RTC_MASK_WDAY       8'h07
`define RTC_MASK_CTL        8'h80

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RTC_CLK_HZ          200000000
`define RTC_SECOND_S        1

`endif

// ### rtc_scratch_ram.v
// scratch byte memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module rtc_scratch_ram #(
  parameter DEPTH = 31,
  parameter AW    = 5
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [7:0]    wdata_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [7:0]    rdata_o
);
  // contents are indeterminate after power-up, so the array has no reset
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// ### rtc_regs_checker.sv
// assertion checker for the two-wire side of the rtc register block
`timescale 1ns/100ps
`default_nettype none
module rtc_regs_checker #(
  parameter [6:0] SLAVE_ID = 7'h50 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o
);
  logic       scl_q, sda_q, busy_q, first_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  wire        st = scl_i & scl_q & sda_q & ~sda_i;
  wire        sp = scl_i & scl_q & ~sda_q & sda_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // bus tracker: bit count, first byte flag and shifted bits
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      busy_q  <= 1'b0;
      first_q <= 1'b0;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      if (st) begin
        busy_q  <= 1'b1;
        first_q <= 1'b1;
        cnt_q   <= 4'h0;
      end else if (sp) begin
        busy_q <= 1'b0;
      end else if (scl_i && !scl_q) begin
        sh_q  <= {sh_q[6:0], sda_i};
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q == 4'h8) first_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_rst_idle;
    $fell(rst_i) |-> sda_oe_n_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line driven at reset release");
  property p_sda_zero;
    sda_o == 1'b0 && (sda_oe_n_o || !sda_i);
  endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("open drain value not low");
  property p_scl_stable;
    scl_i && scl_q |-> $stable(sda_oe_n_o);
  endproperty
  a_scl_stable: assert property (p_scl_stable) else $error("data moved while scl high");
  property p_no_early;
    $fell(sda_oe_n_o) |-> !first_q || cnt_q == 4'h8;
  endproperty
  a_no_early: assert property (p_no_early) else $error("drive inside address byte");
  property p_id_match;
    $fell(sda_oe_n_o) && first_q |-> sh_q[7:1] == SLAVE_ID;
  endproperty
  a_id_match: assert property (p_id_match) else $error("ack for foreign address");
  property p_ack_id;
    $fell(scl_i) && busy_q && first_q && cnt_q == 4'h8 && sh_q[7:1] == SLAVE_ID
      |-> ##[1:8] !sda_oe_n_o;
  endproperty
  a_ack_id: assert property (p_ack_id) else $error("own address not acked");
  property p_ack_hold;
    $fell(sda_oe_n_o) && cnt_q == 4'h8 |-> !sda_oe_n_o [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released too early");
  property p_idle;
    !busy_q |-> sda_oe_n_o;
  endproperty
  a_idle: assert property (p_idle) else $error("line driven while bus idle");
  c_ack: cover property (first_q && $fell(sda_oe_n_o));
  c_rdata: cover property (!first_q && cnt_q < 4'h8 && $fell(sda_oe_n_o));
  c_stop: cover property (sp && busy_q);
endmodule

bind rtc_regs rtc_regs_checker #(.SLAVE_ID(SLAVE_ID)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire

// ### rtc_bus_master.sv
// two-wire bus master model driving the rtc block from the far side
`timescale 1ns/100ps
`default_nettype none
module rtc_bus_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_oe_n_o
);
  // scl low 12 clk, high 4: one 80 ns bit, low long enough for the 3-clk sync
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start_c();
    sda_oe_n_o = 1'b1;
    wt(6);
    scl_o = 1'b1;
    wt(4);
    sda_oe_n_o = 1'b0;
    wt(4);
    scl_o = 1'b0;
  endtask
  task automatic stop_c();
    wt(6);
    sda_oe_n_o = 1'b0;
    wt(6);
    scl_o = 1'b1;
    wt(4);
    sda_oe_n_o = 1'b1;
    wt(4);
  endtask
  task automatic bitx(input logic b, output logic r);
    wt(6);
    sda_oe_n_o = b;
    wt(6);
    scl_o = 1'b1;
    wt(2);
    r = sda_i;
    wt(2);
    scl_o = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  // last byte is not acked so the device lets go of the line
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
endmodule
`default_nettype wire

// ### rtc_timekeeping_register_access_test.sv
// self-checking bench for the rtc register block with a two-wire master model
`timescale 1ns/100ps
`default_nettype none
module rtc_timekeeping_register_access_test;
  localparam logic [6:0] ID  = 7'h2c; // arbitrary value
  localparam int         SEC = 20000;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       scl, m_oe_n, sda_o, d_oe_n;
  logic [7:0] rb [8];
  int         n_errors = 0;
  int         n_checks = 0;
  int         seed = 28;
  int         mdl [64];
  // reset contents, and the calendar one midnight after 31 dec 99, weekday 7
  int         rv [12] = '{0, 0, 0, 1, 1, 1, 'h70, 0, 0, 'h19, 0, 7};
  int         nx [10] = '{0, 0, 0, 1, 1, 1, 0, 0, 0, 'h20};
  // pull-up: low whenever either side pulls
  wire        sda = (d_oe_n | sda_o) & m_oe_n;

  always #2.5 clk_i = ~clk_i;

  rtc_regs #(.SLAVE_ID(ID), .SEC_CYCLES(SEC)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(d_oe_n));
  rtc_bus_master u_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));

  // ----------------------------------------------------------------------
  // transfers and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hdr(input logic [7:0] cmd);
    logic a;
    u_mst.start_c();
    u_mst.wbyte({ID, 1'b0}, a);
    chk({7'h00, a}, 8'h01, "id ack");
    u_mst.wbyte(cmd, a);
    chk({7'h00, a}, 8'h01, "command ack");
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] q [$]);
    logic a;
    hdr(cmd);
    foreach (q[i]) u_mst.wbyte(q[i], a);
    u_mst.stop_c();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n);
    logic a;
    hdr(cmd);
    u_mst.start_c();
    u_mst.wbyte({ID, 1'b1}, a);
    for (int i = 0; i < n; i++) u_mst.rbyte(i == n - 1, rb[i]);
    u_mst.stop_c();
  endtask
  task automatic rchk(input logic [7:0] cmd);
    rd(cmd, 1);
    chk(rb[0], mdl[cmd[6:1]][7:0], "single read");
  endtask
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] v, s0;
    logic [4:0] iq [6];
    int         k;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    for (k = 0; k < 12; k++) begin
      mdl[k] = rv[k];
      rchk({2'b10, k[4:0], 1'b1});
    end
    for (k = 0; k < 6; k++) begin
      iq[k] = (k == 0) ? 5'd30 : 5'(($random(seed) & 'h7fff) % 31);
      v = 8'($random(seed));
      mdl[32 + iq[k]] = v;
      wr({2'b11, iq[k], 1'b0}, '{v});
    end
    for (k = 0; k < 6; k++) rchk({2'b11, iq[k], 1'b1});
    // refused writes: enable bit clear, reserved slot, write protect
    wr(8'h02, '{8'h33});
    wr(8'h96, '{8'h55});
    wr(8'h8e, '{8'hff});
    wr(8'h82, '{8'h12});
    mdl[7] = 'h80;
    rchk(8'h8f);
    rchk(8'h83);
    rchk(8'h97);
    wr(8'h8e, '{8'h00});
    wr(8'h84, '{8'hb1});
    mdl[7] = 0;
    mdl[2] = 'hb1;
    rchk(8'h8f);
    rchk(8'h85);
    wr(8'hbe, '{8'h58, 8'h59, 8'h23, 8'h31, 8'h12, 8'h07, 8'h99, 8'h00});
    for (k = 1; k < 10; k++) mdl[k] = nx[k];
    repeat (2 * SEC) @(negedge clk_i);
    rd(8'hbf, 8);
    chk({rb[0][7:1], 1'b0}, 8'h00, "seconds after carry");
    for (k = 1; k < 8; k++) chk(rb[k], mdl[k][7:0], "burst byte");
    rchk(8'h93);
    do begin
      rd(8'h81, 1);
      s0 = rb[0];
      for (k = 1; k < 10; k++) if (k < 7 || k == 9) rchk({2'b10, k[4:0], 1'b1});
      rd(8'h81, 1);
    end while (s0 == 8'h59 && rb[0] !== s0);
    stop_test();
  end

  // about 70000 cycles of traffic are expected
  initial begin
    repeat (95000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
